// ---- btmc_top.sv ----
// Mode control, pin signalling and transmitter gating of a bus transceiver.
// Assumes analog comparators and supply monitors arrive as asynchronous
// levels, and software reaches the registers over classic Wishbone.
//
// Behaviour
// - Normal mode enables transmitter, normal receiver and undervoltage detector together.
// - Normal, supplies good: error/wake pin LOW when error flag set, else HIGH.
// - Transmitter starts on first LOW data with guardian HIGH, enable LOW.
// - Enabled transmitter with data HIGH drives plus HIGH, minus LOW.
// - Enabled transmitter with data LOW drives plus LOW, minus HIGH.
// - Normal mode receive pin follows receiver: LOW for DATA_0, else HIGH.
// - Activity only after filter time above threshold; then data follows bus.
// - Below threshold for idle filter time declares idle, receive pin HIGH.
// - Standby disables transmitter and receiver; wake receiver only without core undervoltage.
// - Core undervoltage disables wake receiver so wake flag cannot set.
// - Standby, supplies good: both pins LOW when wake flag set, else HIGH.
// - During core undervoltage, receive pin holds wake flag from before it; error/wake pin too, but shows error flag while mode select HIGH.
// - I/O undervoltage forces internal select, guardian, data LOW; enable, clock, select HIGH.
// - Serial status readout refused during I/O undervoltage.
// - Guardian enable ignored in Standby.
// - Power-off disables transmitter and both receivers; wake flag never set.
// - Core supply above recovery level resets digital section, enters Standby.
// - Core supply below detect level returns device to Power-off.
// - Serial status readout refused in Power-off.
// - Wake event in Standby, or while switching into it, sets wake flag.
// - Leaving power-on reset sets power-on flag and both undervoltage flags.
// - Wake pattern needs at least two consecutive wake symbols.
module btmc_top
#(
  parameter logic [btmc_pkg::CNT_W-1:0] WAKE_SPAN_LIMIT = btmc_pkg::WAKE_SPAN_CYC
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [btmc_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Supply monitors
  input wire logic vcc_above_recovery_i,
  input wire logic vcc_below_detect_i,
  input wire logic vio_undervoltage_i,
  input wire logic vcc_undervoltage_i,
  // Controller pins
  input wire logic mode_select_n_i,
  input wire logic transmit_enable_n_i,
  input wire logic guardian_enable_i,
  input wire logic transmit_data_i,
  input wire logic serial_clk_i,
  input wire logic serial_select_n_i,
  input wire logic error_event_i,
  output logic receive_data_o,
  output logic error_wake_out_n_o,
  output logic error_wake_out_n_oe_o,
  output logic serial_out_o,
  output logic serial_out_oe_o,
  // Bus lines
  input wire logic bus_plus_i,
  input wire logic bus_minus_i,
  output logic bus_plus_o,
  output logic bus_plus_oe_o,
  output logic bus_minus_o,
  output logic bus_minus_oe_o,
  // Functional enables
  output logic transmitter_en_o,
  output logic normal_rx_en_o,
  output logic low_power_rx_en_o,
  output logic undervoltage_detector_en_o
);

  if (WAKE_SPAN_LIMIT <= btmc_pkg::WAKE_IDLE_CYC)
  begin : g_bad_span
    $error("btmc_top: WAKE_SPAN_LIMIT too short for two wake symbols");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    btmc_pkg::btmc_mode_type mode;
    logic error_flag;
    logic wake_flag;
    logic power_on_flag_flag;
    logic vio_uv_flag;
    logic vcc_uv_flag;
    logic held_wake;
    logic tx_active;
    logic bus_active;
    logic rx_level;
    logic [btmc_pkg::CNT_W-1:0] act_cnt;
    btmc_pkg::btmc_wake_type wk_state;
    logic [btmc_pkg::CNT_W-1:0] wk_cnt;
    logic wk_syms;
    logic wk_span_on;
    logic [btmc_pkg::CNT_W-1:0] wk_span;
    logic spi_mode;
    logic sclk_prev;
    logic serial_select_n_prev;
    logic [btmc_pkg::STATUS_W-1:0] shift;
    logic ack;
    logic [31:0] rdata;
    logic error_wake_out_n;
    logic error_wake_out_n_oe;
    logic rxd;
    logic plus;
    logic minus;
    logic bus_oe;
    logic serial_out;
    logic sdo_oe;
  } btmc_state_type;

  btmc_state_type st_reg;
  btmc_state_type st_next;

  logic [btmc_pkg::SYNC_W-1:0] pins_sync;
  logic s_vcc_rec;
  logic s_vcc_low;
  logic s_vio_uv;
  logic s_vcc_uv;
  logic s_mode_select_n;
  logic s_transmit_enable_n;
  logic s_bge;
  logic s_txd;
  logic s_sclk;
  logic s_serial_select_n;
  logic s_plus;
  logic s_minus;

  function automatic logic [btmc_pkg::STATUS_W-1:0] btmc_status(input btmc_state_type s);
    logic [btmc_pkg::STATUS_W-1:0] w;
    w = '0;
    w[btmc_pkg::ST_ERROR] = s.error_flag;
    w[btmc_pkg::ST_WAKE] = s.wake_flag;
    w[btmc_pkg::ST_POWER_ON_FLAG] = s.power_on_flag_flag;
    w[btmc_pkg::ST_VIO_UV] = s.vio_uv_flag;
    w[btmc_pkg::ST_VCC_UV] = s.vcc_uv_flag;
    w[btmc_pkg::ST_TX_ACTIVE] = s.tx_active;
    w[btmc_pkg::ST_BUS_ACTIVE] = s.bus_active;
    w[btmc_pkg::ST_MODE_MSB:btmc_pkg::ST_MODE_LSB] = s.mode;
    return w;
  endfunction : btmc_status

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation

  btmc_sync
  #(
    .WIDTH(btmc_pkg::SYNC_W),
    .RST_VAL(btmc_pkg::SYNC_RESET)
  )
  u_sync
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({vcc_above_recovery_i, vcc_below_detect_i, vio_undervoltage_i,
          vcc_undervoltage_i, mode_select_n_i, transmit_enable_n_i,
          guardian_enable_i, transmit_data_i, serial_clk_i, serial_select_n_i,
          bus_plus_i, bus_minus_i}),
    .q_o(pins_sync)
  );

  assign {s_vcc_rec, s_vcc_low, s_vio_uv, s_vcc_uv, s_mode_select_n, s_transmit_enable_n, s_bge, s_txd,
          s_sclk, s_serial_select_n, s_plus, s_minus} = pins_sync;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    logic mode_select_n_int;
    logic bge_int;
    logic txd_int;
    logic transmit_enable_n_int;
    logic sclk_int;
    logic serial_select_n_int;
    logic dif_act;
    logic dif_low;
    logic dif_high;
    logic lp_rx_on;
    logic wake_hit;
    logic wb_req;
    logic spi_ok;
    logic to_normal;
    logic [btmc_pkg::CNT_W-1:0] limit;
    mode_select_n_int = 1'h0;
    bge_int = 1'h0;
    txd_int = 1'h0;
    transmit_enable_n_int = 1'h1;
    sclk_int = 1'h1;
    serial_select_n_int = 1'h1;
    wake_hit = 1'h0;
    to_normal = 1'h0;
    dif_act = 1'h0;
    dif_low = 1'h0;
    dif_high = 1'h0;
    lp_rx_on = 1'h0;
    wb_req = 1'h0;
    spi_ok = 1'h0;
    limit = btmc_pkg::ACT_FILTER_CYC;
    st_next = st_reg;

    // Pins forced to safe levels while the I/O supply is low
    if (!st_reg.vio_uv_flag)
    begin
      mode_select_n_int = s_mode_select_n;
      bge_int = s_bge;
      txd_int = s_txd;
      transmit_enable_n_int = s_transmit_enable_n;
      sclk_int = s_sclk;
      serial_select_n_int = s_serial_select_n;
    end

    dif_act = s_plus ^ s_minus;
    dif_low = s_minus & ~s_plus;
    dif_high = s_plus & ~s_minus;
    lp_rx_on = (st_reg.mode != btmc_pkg::BTMC_POWER_OFF) && !st_reg.vcc_uv_flag;

    // Receiver activity filter, live only in Normal mode
    if (st_reg.mode == btmc_pkg::BTMC_NORMAL)
    begin
      limit = st_reg.bus_active ? btmc_pkg::IDLE_FILTER_CYC : btmc_pkg::ACT_FILTER_CYC;
      if (dif_act == st_reg.bus_active)
      begin
        st_next.act_cnt = '0;
      end
      else if (st_reg.act_cnt + 1'b1 >= limit)
      begin
        st_next.bus_active = dif_act;
        st_next.act_cnt = '0;
      end
      else
      begin
        st_next.act_cnt = st_reg.act_cnt + 1'b1;
      end
      if (!st_next.bus_active)
      begin
        st_next.rx_level = 1'h1;
      end
      else if (dif_high)
      begin
        st_next.rx_level = 1'h1;
      end
      else if (dif_low)
      begin
        st_next.rx_level = 1'h0;
      end
    end
    else
    begin
      limit = btmc_pkg::ACT_FILTER_CYC;
      st_next.bus_active = 1'h0;
      st_next.rx_level = 1'h1;
      st_next.act_cnt = '0;
    end

    // Wake pattern: two DATA_0 then idle symbols inside one span
    if (!lp_rx_on)
    begin
      st_next.wk_state = btmc_pkg::BTMC_WK_WAIT;
      st_next.wk_syms = 1'h0;
      st_next.wk_span_on = 1'h0;
      st_next.wk_cnt = '0;
      st_next.wk_span = '0;
    end
    else
    begin
      if (st_reg.wk_span_on)
      begin
        st_next.wk_span = st_reg.wk_span + 1'b1;
      end
      case (st_reg.wk_state)
        btmc_pkg::BTMC_WK_WAIT:
        begin
          if (dif_low)
          begin
            st_next.wk_state = btmc_pkg::BTMC_WK_LOW;
            st_next.wk_cnt = '0;
            if (!st_reg.wk_span_on)
            begin
              st_next.wk_span_on = 1'h1;
              st_next.wk_span = '0;
            end
          end
        end
        btmc_pkg::BTMC_WK_LOW:
        begin
          if (dif_low)
          begin
            if (st_reg.wk_cnt < btmc_pkg::WAKE_DATA0_CYC)
            begin
              st_next.wk_cnt = st_reg.wk_cnt + 1'b1;
            end
          end
          else if (st_reg.wk_cnt >= btmc_pkg::WAKE_DATA0_CYC)
          begin
            st_next.wk_state = btmc_pkg::BTMC_WK_HIGH;
            st_next.wk_cnt = '0;
          end
          else
          begin
            st_next.wk_state = btmc_pkg::BTMC_WK_WAIT;
            st_next.wk_syms = 1'h0;
            st_next.wk_span_on = 1'h0;
          end
        end
        btmc_pkg::BTMC_WK_HIGH:
        begin
          // Idle or DATA_1 both count as the gap phase
          if (dif_low)
          begin
            st_next.wk_state = btmc_pkg::BTMC_WK_LOW;
            st_next.wk_cnt = '0;
            st_next.wk_syms = 1'h0;
            st_next.wk_span = '0;
          end
          else if (st_reg.wk_cnt + 1'b1 >= btmc_pkg::WAKE_IDLE_CYC)
          begin
            st_next.wk_state = btmc_pkg::BTMC_WK_WAIT;
            st_next.wk_cnt = '0;
            if (st_reg.wk_syms)
            begin
              wake_hit = 1'h1;
              st_next.wk_syms = 1'h0;
              st_next.wk_span_on = 1'h0;
            end
            else
            begin
              st_next.wk_syms = 1'h1;
            end
          end
          else
          begin
            st_next.wk_cnt = st_reg.wk_cnt + 1'b1;
          end
        end
        default:
        begin
          st_next.wk_state = btmc_pkg::BTMC_WK_WAIT;
        end
      endcase
      // Span expiry drops a half-built pattern
      if (st_reg.wk_span_on && st_reg.wk_span >= WAKE_SPAN_LIMIT && !wake_hit)
      begin
        st_next.wk_state = btmc_pkg::BTMC_WK_WAIT;
        st_next.wk_syms = 1'h0;
        st_next.wk_span_on = 1'h0;
        st_next.wk_cnt = '0;
      end
    end

    // Wishbone access, answered one cycle after the strobe
    wb_req = wb_cyc_i && wb_stb_i && !st_reg.ack;
    st_next.ack = wb_req;
    if (wb_req)
    begin
      if (wb_adr_i == btmc_pkg::REG_CTRL)
      begin
        st_next.rdata = {31'h0, st_reg.spi_mode};
        if (wb_we_i && wb_sel_i[0])
        begin
          st_next.spi_mode = wb_dat_i[btmc_pkg::CTRL_SPI_MODE];
        end
      end
      else if (wb_adr_i == btmc_pkg::REG_STATUS)
      begin
        st_next.rdata = {16'h0, btmc_status(st_reg)};
        if (wb_we_i && wb_sel_i[0])
        begin
          // Write one to clear; a same-cycle set below wins
          st_next.error_flag = st_reg.error_flag & ~wb_dat_i[btmc_pkg::ST_ERROR];
          st_next.wake_flag = st_reg.wake_flag & ~wb_dat_i[btmc_pkg::ST_WAKE];
          st_next.power_on_flag_flag = st_reg.power_on_flag_flag & ~wb_dat_i[btmc_pkg::ST_POWER_ON_FLAG];
        end
      end
      else
      begin
        st_next.rdata = 32'h0;
      end
    end

    // Mode sequencing
    case (st_reg.mode)
      btmc_pkg::BTMC_POWER_OFF:
      begin
        if (s_vcc_rec)
        begin
          st_next = '0;
          st_next.mode = btmc_pkg::BTMC_STANDBY;
          st_next.power_on_flag_flag = 1'h1;
          st_next.vio_uv_flag = 1'h1;
          st_next.vcc_uv_flag = 1'h1;
          st_next.rx_level = 1'h1;
          st_next.spi_mode = btmc_pkg::CTRL_SPI_MODE_RESET;
          st_next.sclk_prev = 1'h1;
          st_next.serial_select_n_prev = 1'h1;
          st_next.ack = wb_req;
          st_next.rdata = st_reg.rdata;
        end
      end
      btmc_pkg::BTMC_STANDBY:
      begin
        // Mode select HIGH asks for Normal
        if (mode_select_n_int && !st_reg.vio_uv_flag && !st_reg.vcc_uv_flag)
        begin
          st_next.mode = btmc_pkg::BTMC_NORMAL;
          to_normal = 1'h1;
        end
      end
      btmc_pkg::BTMC_NORMAL:
      begin
        if (!mode_select_n_int || st_reg.vio_uv_flag || st_reg.vcc_uv_flag)
        begin
          st_next.mode = btmc_pkg::BTMC_STANDBY;
        end
      end
      default:
      begin
        st_next.mode = btmc_pkg::BTMC_POWER_OFF;
      end
    endcase

    if (st_reg.mode != btmc_pkg::BTMC_POWER_OFF)
    begin
      st_next.vio_uv_flag = s_vio_uv;
      st_next.vcc_uv_flag = s_vcc_uv;
      if (to_normal)
      begin
        st_next.wake_flag = 1'h0;
        st_next.power_on_flag_flag = 1'h0;
      end
      if (error_event_i)
      begin
        st_next.error_flag = 1'h1;
      end
      if (wake_hit && (st_reg.mode == btmc_pkg::BTMC_STANDBY || !mode_select_n_int))
      begin
        st_next.wake_flag = 1'h1;
      end
      // Holds the pre-undervoltage wake value
      if (!st_reg.vcc_uv_flag)
      begin
        st_next.held_wake = st_reg.wake_flag;
      end
      if (s_vcc_low)
      begin
        st_next.mode = btmc_pkg::BTMC_POWER_OFF;
      end
    end

    // Transmitter gating; guardian only counts in Normal
    if (st_reg.mode == btmc_pkg::BTMC_NORMAL && bge_int && !transmit_enable_n_int)
    begin
      st_next.tx_active = st_reg.tx_active || !txd_int;
    end
    else
    begin
      st_next.tx_active = 1'h0;
    end
    st_next.plus = txd_int;
    st_next.minus = ~txd_int;
    st_next.bus_oe = st_next.tx_active;

    // Serial status shifter
    spi_ok = st_reg.spi_mode && !st_reg.vio_uv_flag
             && st_reg.mode != btmc_pkg::BTMC_POWER_OFF;
    st_next.sclk_prev = sclk_int;
    st_next.serial_select_n_prev = serial_select_n_int;
    if (spi_ok && st_reg.serial_select_n_prev && !serial_select_n_int)
    begin
      st_next.shift = btmc_status(st_reg);
    end
    else if (!serial_select_n_int && !st_reg.sclk_prev && sclk_int)
    begin
      st_next.shift = {st_reg.shift[btmc_pkg::STATUS_W-2:0], 1'h0};
    end
    st_next.serial_out = st_next.shift[btmc_pkg::STATUS_W-1];
    st_next.sdo_oe = spi_ok && !serial_select_n_int;

    // Diagnostic and receive pins
    st_next.error_wake_out_n_oe = 1'h1;
    if (st_next.mode == btmc_pkg::BTMC_POWER_OFF)
    begin
      st_next.error_wake_out_n_oe = 1'h0;
      st_next.error_wake_out_n = 1'h1;
      st_next.rxd = 1'h1;
    end
    else if (st_next.mode == btmc_pkg::BTMC_NORMAL && !st_next.vio_uv_flag
             && !st_next.vcc_uv_flag)
    begin
      st_next.error_wake_out_n = ~st_next.error_flag;
      st_next.rxd = st_next.rx_level;
    end
    else if (st_next.vio_uv_flag)
    begin
      st_next.error_wake_out_n = 1'h0;
      st_next.rxd = 1'h0;
    end
    else if (!st_next.vcc_uv_flag)
    begin
      st_next.error_wake_out_n = ~st_next.wake_flag;
      st_next.rxd = ~st_next.wake_flag;
    end
    else
    begin
      st_next.rxd = ~st_next.held_wake;
      st_next.error_wake_out_n = mode_select_n_int ? ~st_next.error_flag : ~st_next.held_wake;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_reg <= '0;
      st_reg.mode <= btmc_pkg::BTMC_POWER_OFF;
      st_reg.rx_level <= 1'h1;
      st_reg.error_wake_out_n <= 1'h1;
      st_reg.rxd <= 1'h1;
      st_reg.sclk_prev <= 1'h1;
      st_reg.serial_select_n_prev <= 1'h1;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign wb_ack_o = st_reg.ack;
  assign wb_dat_o = st_reg.rdata;
  assign receive_data_o = st_reg.rxd;
  assign error_wake_out_n_o = st_reg.error_wake_out_n;
  assign error_wake_out_n_oe_o = st_reg.error_wake_out_n_oe;
  assign serial_out_o = st_reg.serial_out;
  assign serial_out_oe_o = st_reg.sdo_oe;
  assign bus_plus_o = st_reg.plus;
  assign bus_minus_o = st_reg.minus;
  assign bus_plus_oe_o = st_reg.bus_oe;
  assign bus_minus_oe_o = st_reg.bus_oe;
  assign transmitter_en_o = (st_reg.mode == btmc_pkg::BTMC_NORMAL);
  assign normal_rx_en_o = (st_reg.mode == btmc_pkg::BTMC_NORMAL);
  assign undervoltage_detector_en_o = (st_reg.mode != btmc_pkg::BTMC_POWER_OFF);
  assign low_power_rx_en_o = (st_reg.mode != btmc_pkg::BTMC_POWER_OFF)
                             && !st_reg.vcc_uv_flag;

endmodule : btmc_top

// ---- btmc_pkg.sv ----
// Shared constants for the bus transceiver mode control block.
// Assumes a single 10 MHz clock and a classic Wishbone register port.
package btmc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and filter timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int CNT_W = 10;
  // Least times round up
  localparam int ACT_FILTER_NS = 200;
  localparam int IDLE_FILTER_NS = 400;
  localparam int WAKE_DATA0_NS = 1000;
  localparam int WAKE_IDLE_NS = 1000;
  // Longest time rounds down
  localparam int WAKE_SPAN_NS = 48000;
  localparam logic [CNT_W-1:0] ACT_FILTER_CYC =
    CNT_W'((ACT_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] IDLE_FILTER_CYC =
    CNT_W'((IDLE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] WAKE_DATA0_CYC =
    CNT_W'((WAKE_DATA0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] WAKE_IDLE_CYC =
    CNT_W'((WAKE_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] WAKE_SPAN_CYC = CNT_W'(WAKE_SPAN_NS / CLK_PERIOD_NS);

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
  localparam int CTRL_SPI_MODE = 0;
  localparam logic CTRL_SPI_MODE_RESET = 1'h0;
  localparam int STATUS_W = 16;
  localparam int ST_ERROR = 0;
  localparam int ST_WAKE = 1;
  localparam int ST_POWER_ON_FLAG = 2;
  localparam int ST_VIO_UV = 3;
  localparam int ST_VCC_UV = 4;
  localparam int ST_TX_ACTIVE = 5;
  localparam int ST_BUS_ACTIVE = 6;
  localparam int ST_MODE_LSB = 8;
  localparam int ST_MODE_MSB = 9;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser: {vcc_rec, vcc_det_low, vio_uv, vcc_uv, mode_sel_n,
  // tx_en_n, guardian, tx_data, sclk, select_n, plus, minus}
  localparam int SYNC_W = 12;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 12'h34C;

  ////////////////////////////////////////////////////////////////////////////
  // Modes and wake detector states
  typedef enum logic [1:0] {
    BTMC_POWER_OFF = 2'b00,
    BTMC_STANDBY = 2'b01,
    BTMC_NORMAL = 2'b10
  } btmc_mode_type;

  typedef enum logic [1:0] {
    BTMC_WK_WAIT = 2'b00,
    BTMC_WK_LOW = 2'b01,
    BTMC_WK_HIGH = 2'b10
  } btmc_wake_type;

endpackage : btmc_pkg

// ---- btmc_sync.sv ----
// Two-flip-flop synchroniser for a group of asynchronous pin levels.
// Assumes the inputs are levels; pulses shorter than a clock may be lost.
module btmc_sync
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  if (WIDTH < 1)
  begin : g_bad_width
    $error("btmc_sync: WIDTH must be at least 1");
  end

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } btmc_sync_type;

  btmc_sync_type st_reg;
  btmc_sync_type st_next;

  always_comb
  begin
    st_next.meta = d_i;
    // First stage feeds only the second
    st_next.stable = st_reg.meta;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_reg <= {RST_VAL, RST_VAL};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign q_o = st_reg.stable;

endmodule : btmc_sync

// ---- btmc_monitor.sv ----
// Port checker for the transceiver mode control block.
// Assumes a bind onto btmc_top, one clock and a synchronous reset.
module btmc_monitor
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic guardian_enable_i,
  input wire logic vcc_undervoltage_i,
  input wire logic bus_plus_i,
  input wire logic bus_minus_i,
  input wire logic receive_data_o,
  input wire logic error_wake_out_n_oe_o,
  input wire logic bus_plus_o,
  input wire logic bus_plus_oe_o,
  input wire logic bus_minus_o,
  input wire logic bus_minus_oe_o,
  input wire logic transmitter_en_o,
  input wire logic normal_rx_en_o,
  input wire logic low_power_rx_en_o,
  input wire logic undervoltage_detector_en_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  // Output enable may lag the mode by one registered stage
  tx_gate_a: assert property (
    bus_plus_oe_o |-> transmitter_en_o || $past(transmitter_en_o))
    else $error("bus driven outside Normal");
  drive_pair_a: assert property (
    bus_plus_oe_o |-> bus_minus_oe_o && (bus_minus_o != bus_plus_o))
    else $error("bus lines not driven opposite");
  tx_first_a: assert property (
    $rose(bus_plus_oe_o) |-> !bus_plus_o && bus_minus_o)
    else $error("transmit began without low data");
  guard_off_a: assert property (
    $fell(guardian_enable_i) |-> ##[0:4] !bus_plus_oe_o)
    else $error("guardian low did not stop transmit");
  normal_en_a: assert property (
    transmitter_en_o |-> normal_rx_en_o && undervoltage_detector_en_o)
    else $error("normal enables split");
  off_quiet_a: assert property (
    !undervoltage_detector_en_o |-> !low_power_rx_en_o && !normal_rx_en_o)
    else $error("receiver on in power-off");
  off_pins_a: assert property (
    !error_wake_out_n_oe_o |-> receive_data_o)
    else $error("receive pin low in power-off");
  idle_rx_a: assert property (
    (normal_rx_en_o && (bus_plus_i == bus_minus_i)) [*8] |-> receive_data_o)
    else $error("idle bus left receive pin low");
  vcc_uv_a: assert property (
    vcc_undervoltage_i [*5] |-> !low_power_rx_en_o)
    else $error("wake receiver on in core undervoltage");
  c_tx: cover property ($rose(bus_plus_oe_o));
  c_wake: cover property (low_power_rx_en_o && !receive_data_o);
  c_off: cover property ($fell(error_wake_out_n_oe_o));
endmodule : btmc_monitor

bind btmc_top btmc_monitor u_monitor (.*);

// ---- btmc_bus_far.sv ----
// Far end of the bus lines: a node that drives idle, DATA_0 or DATA_1.
// Assumes the block's drive wins while its enable is high.
module btmc_bus_far
(
  input wire logic [1:0] state_i,
  input wire logic plus_i,
  input wire logic plus_oe_i,
  input wire logic minus_i,
  input wire logic minus_oe_i,
  output logic plus_o,
  output logic minus_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle lines rest at one bias level, so no false activity
  assign plus_o = plus_oe_i ? plus_i : (state_i == 2'h2);
  assign minus_o = minus_oe_i ? minus_i : (state_i == 2'h1);
endmodule : btmc_bus_far

// ---- testbench.sv ----
// Self-checking bench for the transceiver mode control block.
// Assumes btmc_top, the bus far-end model and the bound checker.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, r, wb_dat_o;
  logic vcc_above_recovery_i = 0, vcc_below_detect_i = 0, vio_undervoltage_i = 0;
  logic vcc_undervoltage_i = 0, mode_select_n_i = 0, transmit_enable_n_i = 1;
  logic guardian_enable_i = 0, transmit_data_i = 1, serial_clk_i = 1;
  logic serial_select_n_i = 1, error_event_i = 0;
  logic [1:0] bus_state = 2'h0;
  logic wb_ack_o, receive_data_o, error_wake_out_n_o, error_wake_out_n_oe_o;
  logic serial_out_o, serial_out_oe_o, bus_plus_i, bus_minus_i, bus_plus_o;
  logic bus_plus_oe_o, bus_minus_o, bus_minus_oe_o, transmitter_en_o;
  logic normal_rx_en_o, low_power_rx_en_o, undervoltage_detector_en_o;
  int n_fail = 0, checks_done = 0;

  // Short wake span keeps the run brief
  btmc_top #(.WAKE_SPAN_LIMIT(10'h050)) dut (.*);
  btmc_bus_far u_far (.state_i(bus_state), .plus_i(bus_plus_o),
    .plus_oe_i(bus_plus_oe_o), .minus_i(bus_minus_o), .minus_oe_i(bus_minus_oe_o),
    .plus_o(bus_plus_i), .minus_o(bus_minus_i));

  initial
  begin
    forever #50 clk_i = ~clk_i;
  end
  ////////////////////////////////////////
  task end_sim;
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %0t: got %0h want %0h", $time, got, exp);
    end
  endtask : chk

  task tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    r = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    if (n >= 20)
    begin
      n_fail++;
      end_sim();
    end
  endtask : wb

  // One wake symbol: 13 cycles of DATA_0 then 13 of idle, inside the span limit
  task wake;
    bus_state <= 2'h1;
    tick(13);
    bus_state <= 2'h0;
    tick(13);
  endtask : wake

  initial
  begin
    tick(16);
    rst_i <= 0;
    tick(4);
    chk({error_wake_out_n_oe_o, receive_data_o}, 2'b01);
    chk(low_power_rx_en_o, 0);
    wb(0, 4'h8, 0);
    chk(r, 0);
    wb(1, 4'h0, 32'h1);
    wb(0, 4'h0, 0);
    chk(r, 32'h1);
    vcc_above_recovery_i <= 1;
    tick(8);
    wb(0, 4'h4, 0);
    chk(r, 32'h104);
    chk({error_wake_out_n_o, receive_data_o}, 2'b11);
    $display("test power-up done");
    wb(1, 4'h0, 32'h1);
    serial_select_n_i <= 0;
    tick(5);
    chk({serial_out_oe_o, serial_out_o}, 2'b10);
    vio_undervoltage_i <= 1;
    tick(5);
    chk({serial_out_oe_o, error_wake_out_n_o, receive_data_o}, 3'h0);
    {vio_undervoltage_i, serial_select_n_i} <= 2'b01;
    tick(5);
    $display("test serial done");
    mode_select_n_i <= 1;
    tick(8);
    chk({transmitter_en_o, normal_rx_en_o, undervoltage_detector_en_o}, 3'h7);
    {guardian_enable_i, transmit_enable_n_i} <= 2'b10;
    tick(6);
    chk(bus_plus_oe_o, 0);
    transmit_data_i <= 0;
    tick(10);
    chk({bus_plus_oe_o, bus_plus_o, bus_minus_o, receive_data_o}, 4'hA);
    transmit_data_i <= 1;
    tick(6);
    chk({bus_plus_oe_o, bus_plus_o, bus_minus_o}, 3'h6);
    guardian_enable_i <= 0;
    tick(6);
    chk(bus_plus_oe_o, 0);
    bus_state <= 2'h1;
    tick(10);
    chk(receive_data_o, 0);
    bus_state <= 2'h0;
    tick(10);
    chk(receive_data_o, 1);
    error_event_i <= 1;
    tick(1);
    error_event_i <= 0;
    tick(3);
    chk(error_wake_out_n_o, 0);
    wb(1, 4'h4, 32'h1);
    tick(3);
    chk(error_wake_out_n_o, 1);
    $display("test normal done");
    mode_select_n_i <= 0;
    tick(8);
    chk({transmitter_en_o, low_power_rx_en_o, error_wake_out_n_o}, 3'h3);
    {guardian_enable_i, transmit_data_i} <= 2'b10;
    tick(8);
    chk(bus_plus_oe_o, 0);
    wake();
    chk(error_wake_out_n_o, 1);
    wake();
    tick(3);
    chk({error_wake_out_n_o, receive_data_o}, 2'b00);
    vcc_undervoltage_i <= 1;
    tick(6);
    chk({low_power_rx_en_o, error_wake_out_n_o}, 2'b00);
    mode_select_n_i <= 1;
    tick(4);
    chk({error_wake_out_n_o, receive_data_o}, 2'b10);
    {vcc_below_detect_i, vcc_above_recovery_i} <= 2'b10;
    tick(6);
    chk({error_wake_out_n_oe_o, receive_data_o, undervoltage_detector_en_o}, 3'h2);
    $display("test standby done");
    end_sim();
  end
endmodule : testbench
